// ==== common/adc_seq_pkg.sv ====
/*
  Types of the conversion sequencer: trigger sources and the module's state record.
  Assumes adc_seq_regs.svh is on the include path.
*/
`default_nettype none
`include "adc_seq_regs.svh"
package adc_seq_pkg;
  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_DRV = 3'h1,
    SRC_TMR = 3'h2,
    SRC_SW = 3'h3,
    SRC_CONST = 3'h4
  } src_t;
  typedef struct packed {
    logic en;
    logic cmode;
    src_t src;
    logic [2:0] prog;
    logic [3:0] idx;
    logic busy;
    logic tmr_pend;
    logic sw_pend;
    logic [1:0][31:0] mon;
    logic [`NUM_RES-1:0][11:0] res;
    logic [`NUM_RES-1:0] stored;
    logic [`NUM_RES-1:0] ovr;
    logic [`NUM_TRIG-1:0][2:0] psel;
    logic [`NUM_PROG-1:0][1:0] pirq;
    logic [`NUM_PROG-1:0][3:0][7:0] dprog;
    logic [`NUM_RES-1:0][7:0] tslot;
    logic [`NUM_RES-1:0][7:0] sslot;
    logic [`NUM_RES-1:0][7:0] aslot;
    logic [31:0] rd_data;
    logic conv_start;
    logic conv_abort;
    logic [4:0] conv_channel;
    logic [1:0] conv_phase;
    logic mon0_irq;
    logic mon1_irq;
    logic sw_irq;
    logic tmr_irq;
    logic irq_a;
    logic irq_b;
  } seq_state_t;
endpackage : adc_seq_pkg
`default_nettype wire

// ==== common/adc_seq_regs.svh ====
/*
  Register offsets, field positions, reset values and counts of the conversion sequencer.
  Assumes a 32-bit register port with byte addresses; each register is one aligned word.
*/
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_MON0 8'h08
`define A_MON1 8'h0C
`define A_RES0 8'h10
`define A_PSEL_LO 8'h40
`define A_PSEL_HI 8'h44
`define A_PIRQ 8'h48
`define A_DPROG0 8'h50
`define A_TSLOT0 8'h70
`define A_SSLOT0 8'h80
`define A_ASLOT0 8'h90
`define CTRL_EN 0
`define CTRL_SWSTART 1
`define CTRL_CONST 2
`define MON_EN 0
`define MON_COND 1
`define MON_SEL 7:4
`define MON_VAL 27:16
`define RES_OVR 30
`define RES_STORED 31
`define SLOT_EN 7
`define SLOT_PHASE 6:5
`define SLOT_CHAN 4:0
`define NUM_RES 12
`define NUM_PROG 6
`define NUM_TRIG 12
`define RESET_WORD 32'h0000_0000
`endif

// ==== core/adc_trigger_sequencer.sv ====
/*
  Trigger arbitration and conversion sequencing for one converter unit.
  Assumes an analog core that converts one channel per conv_start and answers with conv_done.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_trigger_sequencer (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Trigger inputs.
  input wire logic [5:0] driver0_trigger,
  input wire logic [5:0] driver1_trigger,
  input wire logic timer_trigger_event,
  // Analog core.
  output logic conv_start,
  output logic conv_abort,
  output logic [4:0] conv_channel,
  output logic [1:0] conv_phase,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // Interrupts.
  output logic monitor0_irq,
  output logic monitor1_irq,
  output logic software_program_done_irq,
  output logic timer_program_done_irq,
  output logic driver_prog_irq_a,
  output logic driver_prog_irq_b
);

  adc_seq_pkg::seq_state_t r;
  adc_seq_pkg::seq_state_t next_r;
  logic [11:0] trig;
  logic drv_hit;
  logic [3:0] drv_num;
  logic [7:0] cfg;
  logic [7:0] cand;
  logic found;
  logic [3:0] found_idx;
  logic store;

  // ---------------------------------------------------------------
  // Slot selection
  // ---------------------------------------------------------------
  function automatic logic [7:0] slot_cfg(input adc_seq_pkg::seq_state_t s,
                                          input logic [3:0] i);
    logic [7:0] v;
    v = 8'h00;
    case (s.src)
      adc_seq_pkg::SRC_DRV: begin
        if (i < 4'h4) begin
          v = s.dprog[s.prog][i[1:0]];
        end
      end
      adc_seq_pkg::SRC_TMR: begin
        v = s.tslot[i];
      end
      adc_seq_pkg::SRC_SW: begin
        v = s.sslot[i];
      end
      adc_seq_pkg::SRC_CONST: begin
        v = s.aslot[i];
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : slot_cfg

  assign trig = {driver1_trigger, driver0_trigger};

  // The lowest-numbered driver trigger wins when several arrive together.
  always_comb begin
    drv_hit = 1'b0;
    drv_num = 4'h0;
    for (int k = `NUM_TRIG - 1; k >= 0; k--) begin
      if (trig[k]) begin
        drv_hit = 1'b1;
        drv_num = 4'(k);
      end
    end
  end

  // The first enabled slot at or after the current one is the next to convert.
  always_comb begin
    found = 1'b0;
    found_idx = 4'h0;
    cfg = 8'h00;
    cand = 8'h00;
    for (int j = `NUM_RES - 1; j >= 0; j--) begin
      cand = slot_cfg(r, 4'(j));
      if (4'(j) >= r.idx && cand[`SLOT_EN]) begin
        found = 1'b1;
        found_idx = 4'(j);
        cfg = cand;
      end
    end
  end

  assign store = r.en && r.busy && conv_done && !drv_hit;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rd_data = 32'h0000_0000;
    next_r.conv_start = 1'b0;
    next_r.conv_abort = 1'b0;
    next_r.mon0_irq = 1'b0;
    next_r.mon1_irq = 1'b0;
    next_r.sw_irq = 1'b0;
    next_r.tmr_irq = 1'b0;
    next_r.irq_a = 1'b0;
    next_r.irq_b = 1'b0;

    // Register writes.
    if (reg_wr) begin
      if (reg_addr == `A_CTRL) begin
        next_r.en = reg_wdata[`CTRL_EN];
        next_r.cmode = reg_wdata[`CTRL_CONST];
        if (reg_wdata[`CTRL_SWSTART] && reg_wdata[`CTRL_EN]) begin
          next_r.sw_pend = 1'b1;
        end
      end else if (reg_addr == `A_MON0) begin
        next_r.mon[0] = reg_wdata;
      end else if (reg_addr == `A_MON1) begin
        next_r.mon[1] = reg_wdata;
      end else if (reg_addr == `A_PSEL_LO) begin
        for (int k = 0; k < 8; k++) begin
          next_r.psel[k] = reg_wdata[4*k +: 3];
        end
      end else if (reg_addr == `A_PSEL_HI) begin
        for (int k = 0; k < 4; k++) begin
          next_r.psel[k+8] = reg_wdata[4*k +: 3];
        end
      end else if (reg_addr == `A_PIRQ) begin
        next_r.pirq = reg_wdata[11:0];
      end else if (reg_addr >= `A_DPROG0 && reg_addr < `A_DPROG0 + 8'h18) begin
        next_r.dprog[3'(reg_addr[7:2] - `A_DPROG0 / 4)] = reg_wdata;
      end else if (reg_addr >= `A_TSLOT0 && reg_addr < `A_TSLOT0 + 8'h0C) begin
        next_r.tslot[4*(reg_addr[3:2]) +: 4] = reg_wdata;
      end else if (reg_addr >= `A_SSLOT0 && reg_addr < `A_SSLOT0 + 8'h0C) begin
        next_r.sslot[4*(reg_addr[3:2]) +: 4] = reg_wdata;
      end else if (reg_addr >= `A_ASLOT0 && reg_addr < `A_ASLOT0 + 8'h0C) begin
        next_r.aslot[4*(reg_addr[3:2]) +: 4] = reg_wdata;
      end
    end

    // Register reads; unmapped addresses read as zero.
    if (reg_rd) begin
      if (reg_addr == `A_CTRL) begin
        next_r.rd_data = {29'h0, r.cmode, 1'b0, r.en};
      end else if (reg_addr == `A_STATUS) begin
        next_r.rd_data = {22'h0, r.idx, r.src, r.sw_pend, r.tmr_pend, r.busy};
      end else if (reg_addr == `A_MON0) begin
        next_r.rd_data = r.mon[0];
      end else if (reg_addr == `A_MON1) begin
        next_r.rd_data = r.mon[1];
      end else if (reg_addr >= `A_RES0 && reg_addr < `A_RES0 + 8'h30) begin
        next_r.rd_data = {r.stored[4'(reg_addr[7:2] - 6'h04)],
                          r.ovr[4'(reg_addr[7:2] - 6'h04)], 18'h0,
                          r.res[4'(reg_addr[7:2] - 6'h04)]};
        next_r.stored[4'(reg_addr[7:2] - 6'h04)] = 1'b0;
        next_r.ovr[4'(reg_addr[7:2] - 6'h04)] = 1'b0;
      end else if (reg_addr == `A_PSEL_LO) begin
        for (int k = 0; k < 8; k++) begin
          next_r.rd_data[4*k +: 4] = {1'b0, r.psel[k]};
        end
      end else if (reg_addr == `A_PSEL_HI) begin
        for (int k = 0; k < 4; k++) begin
          next_r.rd_data[4*k +: 4] = {1'b0, r.psel[k+8]};
        end
      end else if (reg_addr == `A_PIRQ) begin
        next_r.rd_data = {20'h0, r.pirq};
      end else if (reg_addr >= `A_DPROG0 && reg_addr < `A_DPROG0 + 8'h18) begin
        next_r.rd_data = r.dprog[3'(reg_addr[7:2] - `A_DPROG0 / 4)];
      end else if (reg_addr >= `A_TSLOT0 && reg_addr < `A_TSLOT0 + 8'h0C) begin
        next_r.rd_data = r.tslot[4*(reg_addr[3:2]) +: 4];
      end else if (reg_addr >= `A_SSLOT0 && reg_addr < `A_SSLOT0 + 8'h0C) begin
        next_r.rd_data = r.sslot[4*(reg_addr[3:2]) +: 4];
      end else if (reg_addr >= `A_ASLOT0 && reg_addr < `A_ASLOT0 + 8'h0C) begin
        next_r.rd_data = r.aslot[4*(reg_addr[3:2]) +: 4];
      end
    end

    // Sequencing.
    if (!r.en) begin
      next_r.conv_abort = r.busy;
      next_r.busy = 1'b0;
      next_r.src = adc_seq_pkg::SRC_NONE;
      next_r.tmr_pend = 1'b0;
    end else begin
      if (timer_trigger_event) begin
        next_r.tmr_pend = 1'b1;
      end
      if (drv_hit) begin
        next_r.conv_abort = r.busy;
        next_r.busy = 1'b0;
        next_r.src = adc_seq_pkg::SRC_DRV;
        next_r.prog = r.psel[drv_num];
        next_r.idx = 4'h0;
      end else if (store) begin
        // A store counts as a write; the flag set here wins over a read clear.
        next_r.res[r.idx] = conv_result;
        next_r.ovr[r.idx] = r.ovr[r.idx] | r.stored[r.idx];
        next_r.stored[r.idx] = 1'b1;
        next_r.busy = 1'b0;
        next_r.idx = r.idx + 4'h1;
        if (r.mon[0][`MON_EN] && r.mon[0][`MON_SEL] == r.idx) begin
          next_r.mon0_irq = r.mon[0][`MON_COND] ? (conv_result > r.mon[0][`MON_VAL])
                                               : (conv_result < r.mon[0][`MON_VAL]);
        end
        if (r.mon[1][`MON_EN] && r.mon[1][`MON_SEL] == r.idx) begin
          next_r.mon1_irq = r.mon[1][`MON_COND] ? (conv_result > r.mon[1][`MON_VAL])
                                               : (conv_result < r.mon[1][`MON_VAL]);
        end
        if ((r.src == adc_seq_pkg::SRC_SW || r.src == adc_seq_pkg::SRC_CONST) &&
            (r.tmr_pend || timer_trigger_event)) begin
          next_r.src = adc_seq_pkg::SRC_NONE;
        end
      end else if (!r.busy) begin
        if (r.src == adc_seq_pkg::SRC_NONE) begin
          next_r.idx = 4'h0;
          if (r.tmr_pend) begin
            next_r.src = adc_seq_pkg::SRC_TMR;
            next_r.tmr_pend = timer_trigger_event;
          end else if (r.sw_pend) begin
            next_r.src = adc_seq_pkg::SRC_SW;
          end else if (r.cmode) begin
            next_r.src = adc_seq_pkg::SRC_CONST;
          end
        end else if (found) begin
          next_r.conv_start = 1'b1;
          next_r.conv_channel = cfg[`SLOT_CHAN];
          next_r.conv_phase = cfg[`SLOT_PHASE];
          next_r.idx = found_idx;
          next_r.busy = 1'b1;
        end else begin
          next_r.src = adc_seq_pkg::SRC_NONE;
          if (r.src == adc_seq_pkg::SRC_DRV) begin
            next_r.irq_a = r.pirq[r.prog][0] && !r.pirq[r.prog][1];
            next_r.irq_b = r.pirq[r.prog][0] && r.pirq[r.prog][1];
          end else if (r.src == adc_seq_pkg::SRC_TMR) begin
            next_r.tmr_irq = 1'b1;
          end else if (r.src == adc_seq_pkg::SRC_SW) begin
            next_r.sw_irq = 1'b1;
            next_r.sw_pend = 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      next_r_dummy_unused: begin
        r <= '0;
      end
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rd_data;
  assign conv_start = r.conv_start;
  assign conv_abort = r.conv_abort;
  assign conv_channel = r.conv_channel;
  assign conv_phase = r.conv_phase;
  assign monitor0_irq = r.mon0_irq;
  assign monitor1_irq = r.mon1_irq;
  assign software_program_done_irq = r.sw_irq;
  assign timer_program_done_irq = r.tmr_irq;
  assign driver_prog_irq_a = r.irq_a;
  assign driver_prog_irq_b = r.irq_b;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_sw_yield;
    r.src == adc_seq_pkg::SRC_NONE ##1 r.src == adc_seq_pkg::SRC_TMR;
  endsequence

  property p_drv_abort;
    r.en && r.busy && drv_hit |=> conv_abort && r.src == adc_seq_pkg::SRC_DRV && r.idx == 4'h0;
  endproperty
  a_drv_abort: assert property (p_drv_abort) else $error("driver trigger did not abort");

  property p_disable;
    !r.en && r.busy |=> conv_abort && !r.busy && $stable(r.stored);
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not abandon");

  property p_timer_yield;
    store && r.src == adc_seq_pkg::SRC_SW && r.tmr_pend && !reg_wr |=> s_sw_yield;
  endproperty
  a_timer_yield: assert property (p_timer_yield) else $error("timer did not take over");

  property p_sw_done;
    software_program_done_irq |-> !r.sw_pend && r.src == adc_seq_pkg::SRC_NONE && !r.busy;
  endproperty
  a_sw_done: assert property (p_sw_done) else $error("software done too early");

  property p_stored;
    store |=> r.stored[$past(r.idx)] && r.res[$past(r.idx)] == $past(conv_result);
  endproperty
  a_stored: assert property (p_stored) else $error("result not stored");

  property p_overrun;
    store && r.stored[r.idx] |=> r.ovr[$past(r.idx)];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_read_clear;
    reg_rd && reg_addr == `A_RES0 && !(store && r.idx == 4'h0) |=> !r.ovr[0] && !r.stored[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");

  property p_mon0;
    monitor0_irq |-> $past(store) && $past(r.mon[0][`MON_EN]);
  endproperty
  a_mon0: assert property (p_mon0) else $error("monitor 0 fired without a store");

  property p_mon1_cmp;
    store && r.mon[1][`MON_EN] && r.mon[1][`MON_SEL] == r.idx && !r.mon[1][`MON_COND] &&
      conv_result < r.mon[1][`MON_VAL] |=> monitor1_irq;
  endproperty
  a_mon1_cmp: assert property (p_mon1_cmp) else $error("monitor 1 missed a match");

  property p_mon1_off;
    !r.mon[1][`MON_EN] |=> !monitor1_irq;
  endproperty
  a_mon1_off: assert property (p_mon1_off) else $error("monitor 1 fired while off");

  property p_sw_restart;
    r.en && !r.busy && r.src == adc_seq_pkg::SRC_NONE && r.sw_pend && !r.tmr_pend &&
      !drv_hit |=> r.src == adc_seq_pkg::SRC_SW && r.idx == 4'h0;
  endproperty
  a_sw_restart: assert property (p_sw_restart) else $error("software not from slot 0");

  property p_drv_irq_b;
    r.en && !r.busy && !drv_hit && r.src == adc_seq_pkg::SRC_DRV && !found &&
      r.pirq[r.prog] == 2'b11 |=> driver_prog_irq_b && !driver_prog_irq_a;
  endproperty
  a_drv_irq_b: assert property (p_drv_irq_b) else $error("wrong driver interrupt");

  property p_drv_keeps;
    r.en && r.src == adc_seq_pkg::SRC_DRV && !drv_hit |=> r.src != adc_seq_pkg::SRC_TMR;
  endproperty
  a_drv_keeps: assert property (p_drv_keeps) else $error("timer cut a driver program");

  property p_tmr_done;
    timer_program_done_irq |-> $past(r.src) == adc_seq_pkg::SRC_TMR;
  endproperty
  a_tmr_done: assert property (p_tmr_done) else $error("timer done without program");

  property p_off_hold;
    !r.en |=> $stable(r.res);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("result stored while off");

endmodule : adc_trigger_sequencer
`default_nettype wire

// ==== tb/adc_trigger_sequencer_bench.sv ====
/*
  Self-checking bench of the conversion sequencer, driven over its register port and triggers.
  Assumes adc_seq_regs.svh on the include path and the analog core model beside the design.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adc_seq_regs.svh"
module adc_trigger_sequencer_bench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0] drv0 = 6'h00;
  logic [5:0] drv1 = 6'h00;
  logic tmr = 1'b0;
  logic conv_start, conv_abort, conv_done;
  logic [4:0] conv_channel;
  logic [1:0] conv_phase;
  logic [11:0] conv_result;
  logic [11:0] base = 12'h100;
  wire [7:0] ev;
  logic [31:0] d;
  int cnt[8] = '{default: 0};
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  int s;
  logic [6:0] log_q[$];

  adc_trigger_sequencer dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .driver0_trigger(drv0), .driver1_trigger(drv1), .timer_trigger_event(tmr),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_channel(conv_channel),
    .conv_phase(conv_phase), .conv_done(conv_done), .conv_result(conv_result),
    .monitor0_irq(ev[0]), .monitor1_irq(ev[1]), .software_program_done_irq(ev[2]),
    .timer_program_done_irq(ev[3]), .driver_prog_irq_a(ev[4]), .driver_prog_irq_b(ev[5]));
  analog_core_model #(.LAT(6)) core (.clk(clk), .sys_rst(sys_rst), .conv_start(conv_start),
    .conv_abort(conv_abort), .conv_channel(conv_channel), .result_base(base),
    .conv_done(conv_done), .conv_result(conv_result));
  assign ev[6] = conv_abort;
  assign ev[7] = conv_start;

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Event counting and hang guard
  // ----------------------------------------
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (ev[i] === 1'b1) cnt[i] <= cnt[i] + 1;
    end
    if (conv_start === 1'b1) log_q.push_back({conv_phase, conv_channel});
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    check(d, exp, what);
    @(posedge clk);
  endtask : rd_chk

  task automatic wait_cnt(input int idx, input int target);
    for (int i = 0; i < 3000 && cnt[idx] < target; i++) @(posedge clk);
  endtask : wait_cnt

  task automatic chk_log(input logic [6:0] e[$]);
    check(32'(log_q.size()), 32'(e.size()), "conversion count");
    foreach (e[i]) check(32'(log_q[i]), 32'(e[i]), "converted channel");
    log_q.delete();
  endtask : chk_log

  function automatic logic [31:0] rw(input logic st, input logic ov, input logic [11:0] v);
    return {st, ov, 18'h00000, v};
  endfunction : rw

  task automatic sw_run_start;
    log_q.delete();
    s = cnt[7];
    wr(`A_CTRL, 32'h0000_0003);
    wait_cnt(7, s + 1);
  endtask : sw_run_start

  task automatic conclude;
    $display("Checks %0d, failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd_chk(`A_CTRL, `RESET_WORD, "control after reset");
    rd_chk(`A_RES0, `RESET_WORD, "result after reset");
    wr(`A_SSLOT0, 32'h0000_8583);
    wr(`A_DPROG0, 32'h0000_00C7);
    wr(`A_DPROG0 + 8'h04, 32'h0000_0082);
    wr(`A_TSLOT0, 32'h0000_0089);
    wr(`A_PSEL_LO, 32'h0100_0000);
    wr(`A_PIRQ, 32'h0000_000D);
    wr(`A_MON0, 32'h0000_0003);
    wr(`A_MON1, 32'h0FFF_0010);
    // Plain software program with monitor 1 still disabled.
    sw_run_start();
    wait_cnt(2, 1);
    chk_log('{7'h03, 7'h05});
    check(32'(cnt[0]), 32'd1, "monitor0 interrupts");
    check(32'(cnt[1]), 32'd0, "monitor1 interrupts");
    rd_chk(`A_RES0, rw(1'b1, 1'b0, base + 12'h003), "result0 first read");
    rd_chk(`A_RES0, rw(1'b0, 1'b0, base + 12'h003), "result0 second read");
    rd_chk(`A_RES0 + 8'h04, rw(1'b1, 1'b0, base + 12'h005), "result1 read");
    // Driver trigger pre-empts the software program mid-conversion.
    wr(`A_MON1, 32'h0FFF_0011);
    sw_run_start();
    drv0 <= 6'h01;
    @(posedge clk);
    drv0 <= 6'h00;
    wait_cnt(2, 2);
    chk_log('{7'h03, 7'h47, 7'h03, 7'h05});
    check(32'(cnt[6]), 32'd1, "aborts after driver trigger");
    check(32'(cnt[4]), 32'd1, "driver interrupt A");
    check(32'(cnt[0]), 32'd3, "monitor0 interrupts");
    check(32'(cnt[1]), 32'd1, "monitor1 interrupts");
    rd_chk(`A_RES0, rw(1'b1, 1'b1, base + 12'h003), "result0 overrun");
    rd_chk(`A_RES0, rw(1'b0, 1'b0, base + 12'h003), "result0 after read");
    rd_chk(`A_RES0 + 8'h04, rw(1'b1, 1'b0, base + 12'h005), "result1 read");
    // Timer trigger waits for the running software conversion.
    sw_run_start();
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
    wait_cnt(2, 3);
    chk_log('{7'h03, 7'h09, 7'h03, 7'h05});
    check(32'(cnt[3]), 32'd1, "timer interrupts");
    check(32'(cnt[6]), 32'd1, "aborts after timer trigger");
    // Second driver channel picks program 1 with interrupt B.
    drv1 <= 6'h01;
    @(posedge clk);
    drv1 <= 6'h00;
    wait_cnt(5, 1);
    chk_log('{7'h02});
    check(32'(cnt[4]), 32'd1, "driver interrupt A unchanged");
    check(32'(cnt[5]), 32'd1, "driver interrupt B");
    rd_chk(`A_RES0, rw(1'b1, 1'b1, base + 12'h002), "result0 newest kept");
    // Disabling mid-conversion drops the conversion without storing.
    base <= 12'h200;
    sw_run_start();
    wr(`A_CTRL, 32'h0000_0000);
    repeat (12) @(posedge clk);
    rd_chk(`A_RES0, rw(1'b0, 1'b0, 12'h102), "result0 after disable");
    check(32'(cnt[6]), 32'd2, "abort on disable");
    check(32'(cnt[2]), 32'd3, "no software interrupt");
    conclude();
  end
endmodule : adc_trigger_sequencer_bench
`default_nettype wire

// ==== tb/analog_core_model.sv ====
/*
  Behavioural analog core that answers the sequencer's conversion requests.
  Assumes one conversion at a time; each result is result_base plus the converted channel.
*/
`timescale 1ns/10ps
`default_nettype none
module analog_core_model #(
  parameter int LAT = 6
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Sequencer side.
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [4:0] conv_channel,
  input wire logic [11:0] result_base,
  output logic conv_done,
  output logic [11:0] conv_result
);
  int left = 0;
  logic [4:0] chan = 5'h00;
  initial begin
    conv_done = 1'b0;
    conv_result = 12'hA5A;
  end
  // Outside a done pulse the result toggles every cycle, so a stale sample is never a match.
  always @(posedge clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (sys_rst || conv_abort) begin
      left <= 0;
    end else if (conv_start) begin
      left <= LAT;
      chan <= conv_channel;
    end else if (left == 1) begin
      left <= 0;
      conv_done <= 1'b1;
      conv_result <= result_base + {7'h00, chan};
    end else if (left > 1) begin
      left <= left - 1;
    end
  end
endmodule : analog_core_model
`default_nettype wire
